/* logic/urx_pkg.sv */
// Shared constants and types for the serial receiver block
package urx_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] ADR_DATA = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_CTLB = 8'h08;
  localparam logic [7:0] ADR_CTLC = 8'h0c;
  localparam logic [7:0] ADR_BAUD = 8'h10;
  // rx_status_reg fields
  localparam int STAT_RXC = 7;
  localparam int STAT_FE = 4;
  localparam int STAT_DOR = 3;
  localparam int STAT_PE = 2;
  localparam int STAT_U2X = 1;
  // ctrl_reg_b fields
  localparam int CTLB_RXCIE = 7;
  localparam int CTLB_RXEN = 4;
  localparam int CTLB_SZ2 = 2;
  localparam int CTLB_RXB8 = 1;
  // ctrl_reg_c fields
  localparam int CTLC_PM1 = 5;
  localparam int CTLC_PM0 = 4;
  localparam int CTLC_SBS = 3;
  localparam int CTLC_SZ1 = 2;
  localparam int CTLC_SZ0 = 1;
  // Reset values and the nine-bit size code
  localparam logic [2:0] CSZ_RST = 3'h3;
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [11:0] BAUD_RST = 12'h081;
  // Oversampling: samples per bit and first voting sample
  localparam logic [4:0] SPB_NORM = 5'h10;
  localparam logic [4:0] SPB_DBL = 5'h08;
  localparam logic [4:0] VF_NORM = 5'h08;
  localparam logic [4:0] VF_DBL = 5'h04;
  // Buffer entry layout: data[8:0], frame err, overrun, parity err
  localparam int ENTRY_W = 12;
  localparam int ENT_FE = 9;
  localparam int ENT_DOR = 10;
  localparam int ENT_PE = 11;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    URX_IDLE = 3'b000,
    URX_START = 3'b001,
    URX_DATA = 3'b011,
    URX_PAR = 3'b010,
    URX_STOP = 3'b110
  } urx_state_t;
endpackage

/* logic/urx_buf_if.sv */
// Link between receive engine and its frame buffer
`timescale 1ns/1ps
interface urx_buf_if #(parameter int W = 12);
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  modport user (output push, pop, flush, wdata, input rdata, full, empty);
  modport store (input push, pop, flush, wdata, output rdata, full, empty);
endinterface

/* logic/urx_sample_tick.sv */
// Oversample enable divider
`timescale 1ns/1ps
module urx_sample_tick #(
  parameter int DW = 12
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic [DW-1:0] div_i,
  output logic tick_o
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic tick;
  } urx_div_st_t;

  urx_div_st_t st_ff;
  urx_div_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!en_i) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= div_i) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;
endmodule

/* logic/urx_rx_fifo.sv */
// Small receive frame buffer with flush
`timescale 1ns/1ps
module urx_rx_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  urx_buf_if.store bq
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic [CW-1:0] cnt;
  } urx_fifo_st_t;

  urx_fifo_st_t st_ff;
  urx_fifo_st_t nxt_st;
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    do_push = bq.push && (st_ff.cnt != CW'(DEPTH));
    do_pop = bq.pop && (st_ff.cnt != '0);
    if (do_push) begin
      nxt_st.mem[st_ff.wp] = bq.wdata;
      nxt_st.wp = wrap_inc(st_ff.wp);
    end
    if (do_pop) begin
      nxt_st.rp = wrap_inc(st_ff.rp);
    end
    if (do_push && !do_pop) begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end else if (do_pop && !do_push) begin
      nxt_st.cnt = st_ff.cnt - CW'(1);
    end
    // Disable drops unread frames
    if (bq.flush) begin
      nxt_st.rp = '0;
      nxt_st.wp = '0;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bq.rdata = st_ff.mem[st_ff.rp];
  assign bq.full = (st_ff.cnt == CW'(DEPTH));
  assign bq.empty = (st_ff.cnt == '0);
endmodule

/* logic/urx_receiver.sv */
// Serial receiver: start detection, bit recovery, buffered frames, Wishbone regs
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module urx_receiver
  import urx_pkg::*;
#(
  parameter logic [11:0] BAUD_DIV_RST = urx_pkg::BAUD_RST
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_rx_pin_i,
  input wire logic global_irq_en_i,
  output logic rx_irq_o,
  output logic rx_pin_override_o
);
  import urx_pkg::*;

  typedef struct packed {
    urx_state_t state;
    logic [4:0] cnt;
    logic [2:0] votes;
    logic [3:0] bitidx;
    logic [8:0] shreg;
    logic pbit;
    logic last_rx;
    logic pend_vld;
    logic [10:0] pend;
    logic dor;
    logic rx_enable_bit;
    logic rx_complete_irq_en;
    logic double_speed_bit;
    logic parity_enable_bit;
    logic parity_odd_sel;
    logic stop_bits_sel;
    logic [2:0] char_size_sel;
    logic [11:0] baud;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic override;
  } urx_core_st_t;

  // Line history starts high so a line already low at first enable reads as a start edge
  localparam urx_core_st_t ST_RST = '{
    state: URX_IDLE,
    last_rx: 1'b1,
    char_size_sel: CSZ_RST,
    baud: BAUD_DIV_RST,
    default: '0
  };

  urx_core_st_t st_ff;
  urx_core_st_t nxt_st;

  urx_buf_if #(.W(ENTRY_W)) bq ();

  logic tick;
  logic smp;
  logic maj;
  logic dec;
  logic endb;
  logic req;
  logic [4:0] n;
  logic [4:0] vf;
  logic [4:0] vf2;
  logic [4:0] spb;
  logic [3:0] nb;
  logic [8:0] dat9;
  logic [31:0] rd;
  logic push;
  logic pop;
  logic flush;
  logic [ENTRY_W-1:0] head;
  logic act;
  logic in_win;
  logic start_edge;
  logic par_bad;
  logic head_vld;
  logic [2:0] vote3;

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    if (sz == CSZ_NINE) begin
      data_bits = 4'h9;
    end else if (sz[2]) begin
      // Reserved sizes fall back to eight bits
      data_bits = 4'h8;
    end else begin
      data_bits = 4'h5 + {2'b00, sz[1:0]};
    end
  endfunction

  // Divider is held while disabled, so the first tick follows enable
  urx_sample_tick #(.DW(12)) u_tick (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .en_i(st_ff.rx_enable_bit),
    .div_i(st_ff.baud),
    .tick_o(tick)
  );

  urx_rx_fifo #(.W(ENTRY_W), .DEPTH(BUF_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .bq(bq.store)
  );

  assign head = bq.rdata;
  assign bq.push = push;
  assign bq.pop = pop;
  assign bq.flush = flush;
  assign bq.wdata = {st_ff.pend[10], st_ff.dor, st_ff.pend[9:0]};

  always_comb begin
    nxt_st = st_ff;
    smp = serial_rx_pin_i;
    n = st_ff.cnt + 5'h01;
    // Double speed halves samples per bit, trading noise margin for rate
    spb = st_ff.double_speed_bit ? SPB_DBL : SPB_NORM;
    vf = st_ff.double_speed_bit ? VF_DBL : VF_NORM;
    vf2 = vf + 5'h02;
    nb = data_bits(st_ff.char_size_sel);
    vote3 = {st_ff.votes[1:0], smp};
    maj = majority(vote3);
    dat9 = st_ff.shreg >> (4'h9 - nb);
    par_bad = (^dat9 ^ st_ff.pbit) != st_ff.parity_odd_sel;
    head_vld = !bq.empty;
    // Only the centre samples vote, so slow line edges never decide a bit
    in_win = (n == vf) || (n == vf + 5'h01) || (n == vf2);
    act = tick && st_ff.rx_enable_bit && (st_ff.state != URX_IDLE);
    dec = act && (n == vf2);
    endb = act && (n == spb);
    start_edge = tick && st_ff.rx_enable_bit && st_ff.last_rx && !smp;
    push = 1'b0;
    pop = 1'b0;
    flush = !st_ff.rx_enable_bit;
    rd = '0;

    // Bus slave: answer one cycle after the request is seen
    req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    nxt_st.ack = req;
    if (req) begin
      unique case (wb_adr_i)
        ADR_DATA: begin
          // Empty buffer reads zero rather than a stale entry
          if (head_vld) begin
            rd[7:0] = head[7:0];
            pop = !wb_we_i;
          end
        end
        ADR_STAT: begin
          rd[STAT_RXC] = !bq.empty;
          rd[STAT_FE] = !bq.empty && head[ENT_FE];
          rd[STAT_DOR] = !bq.empty && head[ENT_DOR];
          rd[STAT_PE] = !bq.empty && head[ENT_PE] && st_ff.parity_enable_bit;
          rd[STAT_U2X] = st_ff.double_speed_bit;
          // Error positions are read-only; only speed mode is writable
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_st.double_speed_bit = wb_dat_i[STAT_U2X];
          end
        end
        ADR_CTLB: begin
          rd[CTLB_RXCIE] = st_ff.rx_complete_irq_en;
          rd[CTLB_RXEN] = st_ff.rx_enable_bit;
          rd[CTLB_SZ2] = st_ff.char_size_sel[2];
          rd[CTLB_RXB8] = !bq.empty && head[8];
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_st.rx_complete_irq_en = wb_dat_i[CTLB_RXCIE];
            nxt_st.rx_enable_bit = wb_dat_i[CTLB_RXEN];
            nxt_st.char_size_sel[2] = wb_dat_i[CTLB_SZ2];
          end
        end
        ADR_CTLC: begin
          rd[CTLC_PM1] = st_ff.parity_enable_bit;
          rd[CTLC_PM0] = st_ff.parity_odd_sel;
          rd[CTLC_SBS] = st_ff.stop_bits_sel;
          rd[CTLC_SZ1] = st_ff.char_size_sel[1];
          rd[CTLC_SZ0] = st_ff.char_size_sel[0];
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_st.parity_enable_bit = wb_dat_i[CTLC_PM1];
            nxt_st.parity_odd_sel = wb_dat_i[CTLC_PM0];
            // Stop-bit count is kept for the transmitter only
            nxt_st.stop_bits_sel = wb_dat_i[CTLC_SBS];
            nxt_st.char_size_sel[1:0] = wb_dat_i[CTLC_SZ1:CTLC_SZ0];
          end
        end
        ADR_BAUD: begin
          rd[11:0] = st_ff.baud;
          if (wb_we_i && wb_sel_i[0]) begin
            nxt_st.baud[7:0] = wb_dat_i[7:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            nxt_st.baud[11:8] = wb_dat_i[11:8];
          end
        end
        default: begin
          rd = '0;
        end
      endcase
    end
    // Read data stays zero outside the answer cycle
    nxt_st.rdat = rd;

    // Waiting frame moves into the buffer as soon as there is room
    if (st_ff.rx_enable_bit && st_ff.pend_vld && !bq.full) begin
      push = 1'b1;
      nxt_st.pend_vld = 1'b0;
      nxt_st.dor = 1'b0;
    end

    if (tick && st_ff.rx_enable_bit) begin
      nxt_st.last_rx = smp;
      if (st_ff.state != URX_IDLE) begin
        nxt_st.cnt = endb ? 5'h00 : n;
        if (in_win) begin
          nxt_st.votes = vote3;
        end
      end
    end

    unique case (st_ff.state)
      URX_IDLE: begin
        // Counting restarts on every start edge, so each frame resyncs
        if (start_edge) begin
          nxt_st.state = URX_START;
          nxt_st.cnt = 5'h01;
          nxt_st.votes = '0;
          nxt_st.shreg = '0;
          nxt_st.bitidx = '0;
          // Noted at the edge, so a spike rejected later still counts
          if (st_ff.pend_vld && bq.full) begin
            nxt_st.dor = 1'b1;
          end
        end
      end
      URX_START: begin
        if (dec && maj) begin
          nxt_st.state = URX_IDLE;
          nxt_st.cnt = '0;
        end else if (endb) begin
          nxt_st.state = URX_DATA;
        end
      end
      URX_DATA: begin
        if (dec) begin
          // Bits enter at the top; dat9 realigns short frames
          nxt_st.shreg = {maj, st_ff.shreg[8:1]};
          nxt_st.bitidx = st_ff.bitidx + 4'h1;
        end else if (endb && (st_ff.bitidx == nb)) begin
          nxt_st.state = st_ff.parity_enable_bit ? URX_PAR : URX_STOP;
        end
      end
      URX_PAR: begin
        if (dec) begin
          nxt_st.pbit = maj;
        end else if (endb) begin
          nxt_st.state = URX_STOP;
        end
      end
      URX_STOP: begin
        // Frame completes on the first stop bit's vote; line is free again
        if (dec) begin
          nxt_st.state = URX_IDLE;
          nxt_st.cnt = '0;
          nxt_st.pend_vld = 1'b1;
          nxt_st.pend[8:0] = dat9;
          nxt_st.pend[9] = !maj;
          nxt_st.pend[10] = st_ff.parity_enable_bit && par_bad;
        end
      end
      default: begin
        nxt_st.state = URX_IDLE;
      end
    endcase

    // Disable aborts any frame in flight at once
    if (!st_ff.rx_enable_bit) begin
      nxt_st.state = URX_IDLE;
      nxt_st.cnt = '0;
      nxt_st.pend_vld = 1'b0;
      nxt_st.dor = 1'b0;
      nxt_st.last_rx = 1'b1;
    end

    // Only the complete flag feeds the request; error bits never do
    nxt_st.irq = st_ff.rx_complete_irq_en && global_irq_en_i && !bq.empty;
    // Pin hand-back lags the enable by one clock
    nxt_st.override = st_ff.rx_enable_bit;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.rdat;
  assign wb_ack_o = st_ff.ack;
  assign rx_irq_o = st_ff.irq;
  assign rx_pin_override_o = st_ff.override;
endmodule

/* tb/urx_receiver_props.sv */
// Bus, interrupt and pin-ownership properties of the serial receiver
`timescale 1ns/1ps
module urx_receiver_props
  import urx_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_rx_pin_i,
  input wire logic global_irq_en_i,
  input wire logic rx_irq_o,
  input wire logic rx_pin_override_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctlb_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTLB;
  wire data_rd = req && !wb_we_i && wb_adr_i == ADR_DATA;
  chk_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_data_upper: assert property (data_rd |=> wb_dat_o[31:8] == 24'h0)
    else $error("data read upper bits not zero");
  chk_irq_gated: assert property (!global_irq_en_i |=> !rx_irq_o)
    else $error("interrupt while globally disabled");
  chk_pin_follow: assert property (
    ctlb_wr |-> ##2 rx_pin_override_o == $past(wb_dat_i[CTLB_RXEN], 2))
    else $error("pin ownership does not follow enable");
  chk_pin_cause: assert property ($changed(rx_pin_override_o) |-> $past(ctlb_wr, 2))
    else $error("pin ownership changed without write");
  chk_flush_irq: assert property (
    ctlb_wr && !wb_dat_i[CTLB_RXEN] |-> ##3 !rx_irq_o [*4])
    else $error("interrupt survives disable");
  cover property (data_rd);
  cover property ($rose(rx_irq_o));
  cover property ($rose(rx_pin_override_o));
endmodule
bind urx_receiver urx_receiver_props i_props (.mclk_i, .rstn_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_rx_pin_i,
  .global_irq_en_i, .rx_irq_o, .rx_pin_override_o);

/* tb/urx_tx_model.sv */
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module urx_tx_model (
  input wire logic mclk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic hold(input logic v, input int n);
    line_o <= v;
    repeat (n) @(posedge mclk_i);
  endtask
  // One frame LSB first; parity slip and low stop only for error cases
  task automatic send(input logic [8:0] d, input int nd, input int spb, input logic pen,
                      input logic podd, input logic pbad, input logic stop);
    logic p;
    p = ^(d & 9'((1 << nd) - 1)) ^ podd ^ pbad;
    @(posedge mclk_i);
    hold(1'b0, spb);
    for (int i = 0; i < nd; i++) hold(d[i], spb);
    if (pen) hold(p, spb);
    hold(stop, spb);
    hold(1'b1, spb);
  endtask
endmodule

/* tb/test_urx_receiver.sv */
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module test_urx_receiver;
  import urx_pkg::*;
  logic mclk_i, rstn_i, cyc, stb, we, gie, ack, irq, ovr, rx_line;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd, wb_dat_o;
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [31:0] RXC = 32'h1 << STAT_RXC;
  localparam logic [31:0] FE = 32'h1 << STAT_FE;
  localparam logic [31:0] DOR = 32'h1 << STAT_DOR;
  localparam logic [31:0] PE = 32'h1 << STAT_PE;
  localparam logic [31:0] EM = RXC | FE | DOR | PE;
  localparam logic [31:0] EN = 32'h1 << CTLB_RXEN;
  localparam logic [31:0] IE = 32'h1 << CTLB_RXCIE;
  localparam logic [31:0] SZ2 = 32'h1 << CTLB_SZ2;
  localparam logic [31:0] B8 = 32'h1 << CTLB_RXB8;
  localparam logic [31:0] PM1 = 32'h1 << CTLC_PM1;
  localparam logic [31:0] PM0 = 32'h1 << CTLC_PM0;
  localparam logic [31:0] SZ8 = 32'h3 << CTLC_SZ0;
  urx_receiver i_dut (.mclk_i, .rstn_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o(ack),
    .serial_rx_pin_i(rx_line), .global_irq_en_i(gie), .rx_irq_o(irq),
    .rx_pin_override_o(ovr));
  urx_tx_model i_tx (.mclk_i, .line_o(rx_line));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = wb_dat_o;
    {cyc, stb} <= 2'b00;
    chk({31'h0, ack}, 32'h1, "bus answer");
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input string s);
    wb(1'b0, a, 32'h0);
    chk(rd & m, e, s);
  endtask
  task automatic t_regs();
    rdchk(ADR_CTLC, {30'h0, CSZ_RST[1:0]} << CTLC_SZ0, '1, "ctlc reset");
    rdchk(ADR_BAUD, {20'h0, BAUD_RST}, '1, "baud reset");
    rdchk(ADR_STAT, 32'h0, '1, "status reset");
    wb(1'b1, ADR_CTLC, (32'h1 << CTLC_SBS) | SZ8);
    rdchk(ADR_CTLC, (32'h1 << CTLC_SBS) | SZ8, '1, "stop bits kept");
    wb(1'b1, 8'h20, 32'hff);
    rdchk(8'h20, 32'h0, '1, "unmapped");
    wb(1'b1, ADR_BAUD, 32'h0);
  endtask
  task automatic t_basic();
    wb(1'b1, ADR_CTLB, IE | EN);
    i_tx.send(9'h0a5, 8, 16, 0, 0, 0, 1);
    chk({31'h0, irq}, 32'h0, "irq while global off");
    rdchk(ADR_STAT, RXC, EM, "flag after frame");
    gie <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h1, "irq request");
    rdchk(ADR_DATA, 32'ha5, '1, "data byte");
    repeat (3) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0, "irq after read");
    rdchk(ADR_STAT, 32'h0, EM, "flag after read");
  endtask
  task automatic t_nine();
    gie <= 1'b0;
    wb(1'b1, ADR_CTLC, PM1 | SZ8);
    wb(1'b1, ADR_CTLB, EN | SZ2);
    i_tx.send(9'h1a5, 9, 16, 1, 0, 1, 1);
    i_tx.send(9'h0ff, 9, 16, 1, 0, 0, 0);
    rdchk(ADR_STAT, RXC | PE, EM, "first status");
    wb(1'b1, ADR_CTLC, SZ8);
    rdchk(ADR_STAT, RXC, EM, "parity off");
    wb(1'b1, ADR_CTLC, PM1 | SZ8);
    rdchk(ADR_CTLB, B8, B8, "first ninth bit");
    rdchk(ADR_DATA, 32'ha5, '1, "first low byte");
    wb(1'b1, ADR_STAT, 32'h0);
    rdchk(ADR_STAT, RXC | FE, EM, "second status");
    rdchk(ADR_CTLB, 32'h0, B8, "second ninth bit");
    rdchk(ADR_DATA, 32'hff, '1, "second low byte");
    wb(1'b1, ADR_CTLC, PM1 | PM0 | SZ8);
    i_tx.send(9'h003, 9, 16, 1, 1, 0, 1);
    rdchk(ADR_STAT, RXC, EM, "odd parity ok");
    rdchk(ADR_DATA, 32'h03, '1, "odd frame");
  endtask
  task automatic t_ovr();
    wb(1'b1, ADR_CTLC, SZ8);
    wb(1'b1, ADR_CTLB, EN);
    for (int i = 1; i < 5; i++) i_tx.send(9'(8'h11 * i), 8, 16, 0, 0, 0, 1);
    rdchk(ADR_STAT, RXC, EM, "first no overrun");
    rdchk(ADR_DATA, 32'h11, '1, "first kept");
    rdchk(ADR_STAT, RXC, EM, "second no overrun");
    rdchk(ADR_DATA, 32'h22, '1, "second kept");
    rdchk(ADR_STAT, RXC | DOR, EM, "overrun flagged");
    rdchk(ADR_DATA, 32'h44, '1, "last replaces waiting");
    rdchk(ADR_STAT, 32'h0, EM, "drained");
  endtask
  task automatic t_short();
    wb(1'b1, ADR_STAT, 32'h1 << STAT_U2X);
    wb(1'b1, ADR_CTLC, 32'h0);
    i_tx.send(9'h0f5, 5, 8, 0, 0, 0, 1);
    rdchk(ADR_DATA, 32'h15, '1, "five bits double speed");
    wb(1'b1, ADR_STAT, 32'h0);
    wb(1'b1, ADR_CTLC, 32'h1 << CTLC_SZ1);
    wb(1'b1, ADR_CTLB, EN | SZ2);
    i_tx.hold(1'b0, 8);
    i_tx.hold(1'b1, 40);
    rdchk(ADR_STAT, 32'h0, EM, "spike rejected");
    i_tx.send(9'h05a, 8, 16, 0, 0, 0, 1);
    rdchk(ADR_DATA, 32'h5a, '1, "frame after spike");
    wb(1'b1, ADR_CTLC, SZ8);
  endtask
  task automatic t_flush();
    gie <= 1'b1;
    wb(1'b1, ADR_CTLB, IE | EN);
    i_tx.send(9'h012, 8, 16, 0, 0, 0, 1);
    fork
      i_tx.send(9'h0c3, 8, 16, 0, 0, 0, 1);
      begin
        repeat (60) @(posedge mclk_i);
        wb(1'b1, ADR_CTLB, IE);
      end
    join
    rdchk(ADR_STAT, 32'h0, EM, "flushed");
    chk({30'h0, irq, ovr}, 32'h0, "irq and pin released");
    wb(1'b1, ADR_CTLB, IE | EN);
    repeat (20) @(posedge mclk_i);
    rdchk(ADR_STAT, 32'h0, EM, "nothing left");
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    #2000000;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    test_done();
  end
  initial begin
    {rstn_i, cyc, stb, we, gie, adr, sel, wdat} = '0;
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_basic();
    t_nine();
    t_ovr();
    t_short();
    t_flush();
    test_done();
  end
endmodule
